// *** design/smpi_device.sv ***
// Purpose: scan master pin logic: parallel port, chain outputs, chain clock
// Assumes: all host and chain pins are asynchronous to mclk_i
// Notes: pin-driven enables lag the pins by the two-flop synchroniser, except scan_mode_i on data lines 15:14
`timescale 1ns/100ps
`default_nettype none
module smpi_device
  import smpi_pkg::*;
#(
  parameter bit WIDE_MODE = 1'b0,
  parameter int CLK_DIV = SMPI_CLK_DIV
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic rst_n_i,
  smpi_if.dev hp,
  input wire logic out_en_n_i,
  input wire logic scan_mode_i,
  input wire logic scan_out_i,
  output logic scan_in_o,
  input wire logic tdo_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  output logic usr_rd_o,
  output logic usr_wr_o,
  output logic [SMPI_ADDR_W-1:0] usr_addr_o,
  output logic [SMPI_BUS_W-1:0] usr_wdata_o,
  input wire logic [SMPI_BUS_W-1:0] usr_rdata_i,
  input wire logic sm_tdo_i,
  input wire logic sm_tms_i,
  input wire logic sm_trst_n_i,
  input wire logic sm_clk_en_i,
  output logic sm_tick_o,
  output logic sm_tdi_o,
  input wire logic chain_data_in_i,
  output logic chain_data_out_o,
  output logic chain_data_out_oe_o,
  output logic chain_mode_sel_o,
  output logic chain_mode_sel_oe_o,
  output logic chain_clk_o,
  output logic chain_clk_oe_o,
  output logic chain_reset_a_o,
  output logic chain_reset_a_oe_o,
  output logic chain_reset_b_o,
  output logic chain_reset_b_oe_o,
  output logic chain_hiz_flag_o
);
  localparam int SW = 5 + SMPI_ADDR_W + SMPI_BUS_W;
  localparam logic [SW-1:0] SYNC_RST = {3'b110, 1'b1, 1'b0, {(SMPI_ADDR_W + SMPI_BUS_W){1'b0}}};

  // ****************************************************************
  // pin synchroniser
  // ****************************************************************
  logic [SW-1:0] pins, s1_q, s2_q;
  logic s_strobe_n, s_sel_n, s_rd, s_oe_n, s_chain_in;
  logic [SMPI_ADDR_W-1:0] s_addr;
  logic [SMPI_BUS_W-1:0] s_data;
  assign pins = {hp.xfer_strobe_n, hp.port_sel_n, hp.rd_wr, out_en_n_i, chain_data_in_i,
                 hp.addr, hp.data};
  // resets to constants only: strobe and select idle high, enable idle off
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= SYNC_RST;
      s2_q <= SYNC_RST;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
    end
  end
  assign {s_strobe_n, s_sel_n, s_rd, s_oe_n, s_chain_in, s_addr, s_data} = s2_q;

  // ****************************************************************
  // parallel port sequencer
  // ****************************************************************
  smpi_dev_e st_q, st_d;
  logic rd_q, rd_d;
  logic wr_q, wr_d;
  logic is_rd_q, is_rd_d;
  logic ack_q, ack_d;
  logic [SMPI_ADDR_W-1:0] addr_q, addr_d;
  logic [SMPI_BUS_W-1:0] wdata_q, wdata_d;
  logic [SMPI_BUS_W-1:0] rdata_q, rdata_d;
  logic strobe_lo;
  assign strobe_lo = !s_strobe_n && !s_sel_n;

  // select may stay low between transfers; only the strobe edges frame them
  always_comb begin
    st_d = st_q;
    rd_d = 1'b0;
    wr_d = 1'b0;
    is_rd_d = is_rd_q;
    ack_d = ack_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    case (st_q)
      SMPI_D_IDLE: begin
        ack_d = 1'b1;
        if (strobe_lo) begin
          addr_d = s_addr;
          is_rd_d = s_rd;
          wdata_d = s_data;
          if (s_rd) begin
            rd_d = 1'b1;
            st_d = SMPI_D_FETCH;
          end else begin
            ack_d = 1'b0;
            st_d = SMPI_D_ACTIVE;
          end
        end
      end
      SMPI_D_FETCH: begin
        rdata_d = usr_rdata_i;
        ack_d = 1'b0;
        st_d = SMPI_D_ACTIVE;
      end
      SMPI_D_ACTIVE: begin
        if (!is_rd_q) begin
          wdata_d = s_data; // data holds to the strobe's rising edge
        end
        if (!strobe_lo) begin
          wr_d = !is_rd_q;
          ack_d = 1'b1;
          st_d = SMPI_D_IDLE;
        end
      end
      default: begin
        st_d = SMPI_D_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= SMPI_D_IDLE;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      is_rd_q <= 1'b0;
      ack_q <= 1'b1;
      addr_q <= '0;
      wdata_q <= SMPI_DATA_RST;
      rdata_q <= SMPI_DATA_RST;
    end else if (reset_i) begin
      st_q <= SMPI_D_IDLE;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      is_rd_q <= 1'b0;
      ack_q <= 1'b1;
      addr_q <= '0;
      wdata_q <= SMPI_DATA_RST;
      rdata_q <= SMPI_DATA_RST;
    end else begin
      st_q <= st_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      is_rd_q <= is_rd_d;
      ack_q <= ack_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
    end
  end

  assign usr_rd_o = rd_q;
  assign usr_wr_o = wr_q;
  assign usr_addr_o = addr_q;
  assign usr_wdata_o = wdata_q;

  // ****************************************************************
  // data bus and acknowledge drivers
  // ****************************************************************
  logic drive_rd;
  // read data only once fetched, so the bus never shows stale words
  assign drive_rd = strobe_lo && is_rd_q && (st_q == SMPI_D_ACTIVE);
  assign hp.xfer_ack_n_out = ack_q || !strobe_lo; // lifts with the data enable
  assign hp.xfer_ack_n_oe = !s_sel_n;

  genvar gi;
  generate
    for (gi = 0; gi < SMPI_BUS_W; gi++) begin : g_bit
      if (gi >= SMPI_PKG_W) begin : g_wide
        assign hp.dev_data[gi] = rdata_q[gi];
        assign hp.dev_data_oe[gi] = WIDE_MODE && drive_rd;
      end else if (gi == SMPI_SCAN_IN_BIT) begin : g_scan_in
        assign hp.dev_data[gi] = rdata_q[gi];
        assign hp.dev_data_oe[gi] = !scan_mode_i && drive_rd;
      end else if (gi == SMPI_SCAN_OUT_BIT) begin : g_scan_out
        assign hp.dev_data[gi] = scan_mode_i ? scan_out_i : rdata_q[gi];
        assign hp.dev_data_oe[gi] = scan_mode_i || drive_rd;
      end else begin : g_norm
        assign hp.dev_data[gi] = rdata_q[gi];
        assign hp.dev_data_oe[gi] = drive_rd;
      end
    end
  endgenerate
  assign scan_in_o = s_data[SMPI_SCAN_IN_BIT];

  // ****************************************************************
  // chain side
  // ****************************************************************
  logic tdo_q, tms_q, trst_q, own_tdo_q, tdi_q;
  logic chain_oe;
  assign chain_oe = !s_oe_n;

  // chain clock from the one system clock, no second domain
  smpi_clkdiv #(
    .DIV(CLK_DIV)
  ) u_div (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .rst_n_i(rst_n_i),
    .en_i(sm_clk_en_i),
    .clk_o(chain_clk_o),
    .tick_o(sm_tick_o)
  );

  // outputs launch from flops; returning data is the synchronised copy
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tdo_q <= 1'b0;
      tms_q <= 1'b1;
      trst_q <= 1'b0;
      own_tdo_q <= 1'b0;
      tdi_q <= 1'b0;
    end else if (reset_i) begin
      tdo_q <= 1'b0;
      tms_q <= 1'b1;
      trst_q <= 1'b0;
      own_tdo_q <= 1'b0;
      tdi_q <= 1'b0;
    end else begin
      tdo_q <= sm_tdo_i;
      tms_q <= sm_tms_i;
      trst_q <= sm_trst_n_i;
      own_tdo_q <= tdo_i;
      tdi_q <= s_chain_in;
    end
  end

  assign sm_tdi_o = tdi_q;
  assign chain_data_out_o = tdo_q;
  assign chain_mode_sel_o = tms_q;
  assign chain_reset_a_o = trst_q;
  assign chain_reset_b_o = trst_q;
  assign chain_data_out_oe_o = chain_oe;
  assign chain_mode_sel_oe_o = chain_oe;
  assign chain_clk_oe_o = chain_oe;
  assign chain_reset_a_oe_o = chain_oe;
  assign chain_reset_b_oe_o = WIDE_MODE && chain_oe;
  assign chain_hiz_flag_o = !chain_oe;
  assign tdo_o = own_tdo_q;
  assign tdo_oe_o = chain_oe;
endmodule
`default_nettype wire

// *** design/smpi_pkg.sv ***
// Purpose: shared constants and types for the scan master pin interface
// Assumes: one system clock of 25 MHz drives both ends
// Notes: bus carries 32 lines; packaged width uses the low 16
package smpi_pkg;
  // ****************************************************************
  // widths and bit positions
  // ****************************************************************
  localparam int SMPI_BUS_W = 32;
  localparam int SMPI_PKG_W = 16;
  localparam int SMPI_ADDR_W = 5;
  localparam int SMPI_SCAN_IN_BIT = 15;
  localparam int SMPI_SCAN_OUT_BIT = 14;
  // ****************************************************************
  // timing counts and reset values
  // ****************************************************************
  localparam int SMPI_CLK_DIV = 4;
  localparam int SMPI_SETUP_CYC = 2;
  localparam logic [31:0] SMPI_DATA_RST = 32'h0000_0000;
  // ****************************************************************
  // state types
  // ****************************************************************
  typedef enum {SMPI_D_IDLE, SMPI_D_FETCH, SMPI_D_ACTIVE} smpi_dev_e;
  typedef enum {SMPI_H_IDLE, SMPI_H_SETUP, SMPI_H_STROBE, SMPI_H_HOLD} smpi_host_e;
endpackage

// *** design/smpi_if.sv ***
// Purpose: pin bundle between processor and scan master parallel port
// Assumes: undriven lines read as the pull value (data 0, ack high)
// Notes: wire levels are resolved here from the enables
`timescale 1ns/100ps
`default_nettype none
interface smpi_if;
  import smpi_pkg::*;
  logic rd_wr;
  logic xfer_strobe_n;
  logic port_sel_n;
  logic [SMPI_ADDR_W-1:0] addr;
  logic [SMPI_BUS_W-1:0] host_data;
  logic host_data_oe;
  logic [SMPI_BUS_W-1:0] dev_data;
  logic [SMPI_BUS_W-1:0] dev_data_oe;
  logic xfer_ack_n_out;
  logic xfer_ack_n_oe;
  logic [SMPI_BUS_W-1:0] data;
  logic xfer_ack_n;
  // wire resolution; undriven ack floats to its pull-up
  assign data = (dev_data & dev_data_oe) | (host_data & {SMPI_BUS_W{host_data_oe}});
  assign xfer_ack_n = xfer_ack_n_oe ? xfer_ack_n_out : 1'b1;
  modport dev (
    input rd_wr, xfer_strobe_n, port_sel_n, addr, data,
    output dev_data, dev_data_oe, xfer_ack_n_out, xfer_ack_n_oe
  );
  modport host (
    output rd_wr, xfer_strobe_n, port_sel_n, addr, host_data, host_data_oe,
    input data, xfer_ack_n
  );
endinterface
`default_nettype wire

// *** design/smpi_clkdiv.sv ***
// Purpose: chain clock made from the system clock by gating and division
// Assumes: DIV of at least 2
// Notes: tick_o pulses one cycle ahead of each chain clock rising edge
`timescale 1ns/100ps
`default_nettype none
module smpi_clkdiv #(
  parameter int DIV = 4
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  output logic clk_o,
  output logic tick_o
);
  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  localparam logic [CW-1:0] HALF = CW'(DIV / 2);
  logic [CW-1:0] cnt_q, cnt_d;
  logic clk_q, clk_d;
  // ****************************************************************
  // divider
  // ****************************************************************
  // gate holds the counter at zero so the chain clock parks low next cycle, cutting any high phase short
  always_comb begin
    cnt_d = cnt_q;
    clk_d = clk_q;
    if (!en_i) begin
      cnt_d = '0;
      clk_d = 1'b0;
    end else begin
      cnt_d = (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
      clk_d = (cnt_d >= HALF);
    end
  end
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
      clk_q <= 1'b0;
    end else if (reset_i) begin
      cnt_q <= '0;
      clk_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      clk_q <= clk_d;
    end
  end
  assign clk_o = clk_q; // buffered from a flop
  assign tick_o = en_i && (cnt_q == HALF - 1'b1);
endmodule
`default_nettype wire

// *** design/smpi_host.sv ***
// Purpose: processor end that runs strobed transfers on the parallel port
// Assumes: device answers every strobe with an acknowledge
// Notes: select stays low while requests keep coming
`timescale 1ns/100ps
`default_nettype none
module smpi_host
  import smpi_pkg::*;
#(
  parameter int SETUP_CYC = SMPI_SETUP_CYC
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  smpi_if.host hp,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic req_rd_i,
  input wire logic [SMPI_ADDR_W-1:0] req_addr_i,
  input wire logic [SMPI_BUS_W-1:0] req_wdata_i,
  output logic rsp_valid_o,
  output logic [SMPI_BUS_W-1:0] rsp_rdata_o
);
  localparam int CW = $clog2(SETUP_CYC + 1);
  // ****************************************************************
  // acknowledge and data synchroniser
  // ****************************************************************
  logic [SMPI_BUS_W:0] s1_q, s2_q;
  logic s_ack_n;
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      s1_q <= {1'b1, SMPI_DATA_RST};
      s2_q <= {1'b1, SMPI_DATA_RST};
    end else begin
      s1_q <= {hp.xfer_ack_n, hp.data};
      s2_q <= s1_q;
    end
  end
  assign s_ack_n = s2_q[SMPI_BUS_W];

  // ****************************************************************
  // transfer sequencer
  // ****************************************************************
  smpi_host_e st_q, st_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic sel_n_q, sel_n_d;
  logic stb_n_q, stb_n_d;
  logic rd_q, rd_d;
  logic [SMPI_ADDR_W-1:0] addr_q, addr_d;
  logic [SMPI_BUS_W-1:0] wdata_q, wdata_d;
  logic [SMPI_BUS_W-1:0] rdata_q, rdata_d;
  logic rsp_q, rsp_d;

  // setup wait keeps address and data stable ahead of the falling strobe
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sel_n_d = sel_n_q;
    stb_n_d = stb_n_q;
    rd_d = rd_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    rsp_d = 1'b0;
    case (st_q)
      SMPI_H_IDLE: begin
        if (req_valid_i) begin
          sel_n_d = 1'b0;
          rd_d = req_rd_i;
          addr_d = req_addr_i;
          wdata_d = req_wdata_i;
          cnt_d = '0;
          st_d = SMPI_H_SETUP;
        end else begin
          sel_n_d = 1'b1;
        end
      end
      SMPI_H_SETUP: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == CW'(SETUP_CYC - 1)) begin
          stb_n_d = 1'b0;
          st_d = SMPI_H_STROBE;
        end
      end
      SMPI_H_STROBE: begin
        if (!s_ack_n) begin
          rdata_d = s2_q[SMPI_BUS_W-1:0];
          stb_n_d = 1'b1;
          st_d = SMPI_H_HOLD;
        end
      end
      SMPI_H_HOLD: begin
        if (s_ack_n) begin
          rsp_d = 1'b1;
          st_d = SMPI_H_IDLE; // select left low for a back-to-back request
        end
      end
      default: begin
        st_d = SMPI_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st_q <= SMPI_H_IDLE;
      cnt_q <= '0;
      sel_n_q <= 1'b1;
      stb_n_q <= 1'b1;
      rd_q <= 1'b1;
      addr_q <= '0;
      wdata_q <= SMPI_DATA_RST;
      rdata_q <= SMPI_DATA_RST;
      rsp_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sel_n_q <= sel_n_d;
      stb_n_q <= stb_n_d;
      rd_q <= rd_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      rsp_q <= rsp_d;
    end
  end

  assign req_ready_o = (st_q == SMPI_H_IDLE);
  assign rsp_valid_o = rsp_q;
  assign rsp_rdata_o = rdata_q;
  assign hp.port_sel_n = sel_n_q;
  assign hp.xfer_strobe_n = stb_n_q;
  assign hp.rd_wr = rd_q;
  assign hp.addr = addr_q;
  assign hp.host_data = wdata_q;
  assign hp.host_data_oe = !rd_q && !sel_n_q && (st_q != SMPI_H_IDLE); // write only
endmodule
`default_nettype wire

// *** tb/smpi_assertions.sv ***
// Purpose: concurrent checks on the parallel link between both ends
// Assumes: narrow mode; bits 15:14 may serve the scan pins
// Notes: instantiated beside the interface, no bind
`timescale 1ns/100ps
`default_nettype none
module smpi_assertions
  import smpi_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic rd_wr,
  input wire logic xfer_strobe_n,
  input wire logic port_sel_n,
  input wire logic host_data_oe,
  input wire logic [SMPI_BUS_W-1:0] dev_data_oe,
  input wire logic xfer_ack_n_oe,
  input wire logic xfer_ack_n
);
  // ****************************************************************
  // link checks
  // ****************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // scan pins excluded so scan mode cannot trip the release checks
  logic [SMPI_BUS_W-1:0] bus_oe;
  assign bus_oe = dev_data_oe & 32'hffff_3fff;
  sel_release_a: assert property (port_sel_n [*5] |-> bus_oe == 32'h0 && !xfer_ack_n_oe)
    else $error("data or ack driven while deselected");
  strobe_release_a: assert property (xfer_strobe_n [*5] |-> bus_oe == 32'h0)
    else $error("data driven while strobe high");
  wide_off_a: assert property (dev_data_oe[31:16] == 16'h0)
    else $error("upper data lines driven in narrow mode");
  ack_framed_a: assert property ($fell(xfer_ack_n) |-> !port_sel_n && !xfer_strobe_n)
    else $error("ack outside a framed transfer");
  strobe_held_a: assert property ($rose(xfer_strobe_n) |-> !xfer_ack_n)
    else $error("strobe ended before ack");
  ack_release_a: assert property ($rose(xfer_strobe_n) |-> ##[1:6] xfer_ack_n)
    else $error("ack not released after strobe");
  ack_answer_a: assert property ($fell(xfer_strobe_n) |-> ##[2:10] !xfer_ack_n)
    else $error("strobe not answered");
  read_drive_a: assert property (!xfer_ack_n && rd_wr |-> &dev_data_oe[13:0])
    else $error("read ack without data");
  write_quiet_a: assert property (!xfer_ack_n && !rd_wr |-> bus_oe == 32'h0)
    else $error("device drives bus on write");
  no_clash_a: assert property (host_data_oe |-> bus_oe == 32'h0)
    else $error("bus driven by both ends");
  cover property ($fell(xfer_ack_n) && rd_wr);
  cover property ($fell(xfer_ack_n) && !rd_wr);
  cover property (!port_sel_n throughout ($rose(xfer_strobe_n) ##[1:20] $fell(xfer_strobe_n)));
endmodule
`default_nettype wire

// *** tb/scan_master_pin_interface_tb.sv ***
// Purpose: self-checking bench joining host and device ends
// Assumes: narrow mode, chain clock divide of 4
// Notes: inputs change on the falling edge, except rst_n_i falling 5 ns after one; fixed seed
`timescale 1ns/100ps
`default_nettype none
module scan_master_pin_interface_tb;
  import smpi_pkg::*;
  localparam int DIV = 4;
  logic mclk_i = 1'b0, reset_i = 1'b1, rst_n_i = 1'b1;
  logic out_en_n_i = 1'b0, scan_mode_i = 1'b0, scan_out_i = 1'b0, tdo_i = 1'b0;
  logic sm_tdo_i = 1'b0, sm_tms_i = 1'b0, sm_trst_n_i = 1'b1, sm_clk_en_i = 1'b0;
  logic chain_data_in_i = 1'b0, req_valid_i = 1'b0, req_rd_i = 1'b0;
  logic [4:0] req_addr_i = 5'h0;
  logic [31:0] req_wdata_i = 32'h0, usr_rdata_i = 32'h0;
  logic scan_in_o, tdo_o, tdo_oe_o, usr_rd_o, usr_wr_o, sm_tick_o, sm_tdi_o;
  logic [4:0] usr_addr_o;
  logic [31:0] usr_wdata_o, rsp_rdata_o, wr_addr_q, wr_data_q;
  logic wr_scan_q;
  logic chain_data_out_o, chain_data_out_oe_o, chain_mode_sel_o, chain_mode_sel_oe_o;
  logic chain_clk_o, chain_clk_oe_o, chain_reset_a_o, chain_reset_a_oe_o;
  logic chain_reset_b_o, chain_reset_b_oe_o, chain_hiz_flag_o, req_ready_o, rsp_valid_o;
  int failures = 0, check_count = 0, wr_cnt = 0, rd_cnt = 0;
  integer seed = 32'h902ff3e9;
  // ****************************************************************
  // clock, ends and checker
  // ****************************************************************
  always #20 mclk_i = ~mclk_i;
  smpi_if bus();
  smpi_device #(.WIDE_MODE(1'b0), .CLK_DIV(DIV)) smpi_device_inst (.mclk_i, .reset_i,
    .rst_n_i, .hp(bus), .out_en_n_i, .scan_mode_i, .scan_out_i, .scan_in_o, .tdo_i,
    .tdo_o, .tdo_oe_o, .usr_rd_o, .usr_wr_o, .usr_addr_o, .usr_wdata_o, .usr_rdata_i,
    .sm_tdo_i, .sm_tms_i, .sm_trst_n_i, .sm_clk_en_i, .sm_tick_o, .sm_tdi_o,
    .chain_data_in_i, .chain_data_out_o, .chain_data_out_oe_o, .chain_mode_sel_o,
    .chain_mode_sel_oe_o, .chain_clk_o, .chain_clk_oe_o, .chain_reset_a_o,
    .chain_reset_a_oe_o, .chain_reset_b_o, .chain_reset_b_oe_o, .chain_hiz_flag_o);
  smpi_host #(.SETUP_CYC(SMPI_SETUP_CYC)) smpi_host_inst (.mclk_i, .reset_i, .hp(bus),
    .req_valid_i, .req_ready_o, .req_rd_i, .req_addr_i, .req_wdata_i, .rsp_valid_o,
    .rsp_rdata_o);
  smpi_assertions smpi_assertions_inst (.mclk_i, .reset_i, .rd_wr(bus.rd_wr),
    .xfer_strobe_n(bus.xfer_strobe_n), .port_sel_n(bus.port_sel_n),
    .host_data_oe(bus.host_data_oe), .dev_data_oe(bus.dev_data_oe),
    .xfer_ack_n_oe(bus.xfer_ack_n_oe), .xfer_ack_n(bus.xfer_ack_n));
  // user side capture; counts pulses so a stretched pulse shows up
  always @(posedge mclk_i) begin
    if (usr_wr_o === 1'b1) begin
      wr_addr_q <= 32'(usr_addr_o);
      wr_data_q <= usr_wdata_o;
      wr_scan_q <= scan_in_o;
      wr_cnt <= wr_cnt + 1;
    end
    if (usr_rd_o === 1'b1) rd_cnt <= rd_cnt + 1;
  end
  // ****************************************************************
  // helpers
  // ****************************************************************
  // only the low lines carry data in narrow mode
  function automatic logic [31:0] narrow(input logic [31:0] v);
    return v & 32'h0000_ffff;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // one host request, checked at the user side of the device
  task automatic xfer(input logic rd, input logic [4:0] ad, input logic [31:0] wd);
    int n = 0;
    int w0 = wr_cnt;
    int r0 = rd_cnt;
    while (req_ready_o !== 1'b1 && n < 50) begin
      @(negedge mclk_i);
      n++;
    end
    usr_rdata_i = $random(seed);
    req_valid_i = 1'b1;
    req_rd_i = rd;
    req_addr_i = ad;
    req_wdata_i = wd;
    @(negedge mclk_i);
    req_valid_i = 1'b0;
    while (rsp_valid_o !== 1'b1 && n < 100) begin
      @(negedge mclk_i);
      n++;
    end
    if (n >= 100) failures++; // a hung transfer counts as a mismatch
    check(32'(wr_cnt - w0), rd ? 32'h0 : 32'h1);
    check(32'(rd_cnt - r0), rd ? 32'h1 : 32'h0);
    if (rd) check(rsp_rdata_o, narrow(usr_rdata_i));
    else begin
      check(wr_addr_q, 32'(ad));
      check(narrow(wr_data_q), narrow(wd));
      check(32'(wr_scan_q), 32'(wd[SMPI_SCAN_IN_BIT]));
    end
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    logic [31:0] r;
    int last;
    logic prev_clk, prev_tick;
    repeat (5) @(negedge mclk_i);
    reset_i = 1'b0;
    // chain outputs follow their sources; enable drawn at random
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      {out_en_n_i, tdo_i, chain_data_in_i, sm_trst_n_i, sm_tms_i, sm_tdo_i} = r[5:0];
      repeat (5) @(negedge mclk_i);
      check(32'({chain_data_out_o, chain_mode_sel_o, chain_reset_a_o}),
            32'({r[0], r[1], r[2]}));
      check(32'({sm_tdi_o, tdo_o, chain_reset_b_o}), 32'({r[3], r[4], r[2]}));
      check(32'({chain_data_out_oe_o, chain_mode_sel_oe_o, chain_clk_oe_o,
             chain_reset_a_oe_o}), 32'({4{~r[5]}}));
      check(32'({tdo_oe_o, chain_hiz_flag_o}), 32'({~r[5], r[5]}));
      check(32'(chain_reset_b_oe_o), 32'h0);
    end
    out_en_n_i = 1'b0;
    // chain clock period and its lead tick
    sm_clk_en_i = 1'b1;
    last = -1;
    prev_clk = chain_clk_o;
    prev_tick = 1'b0;
    for (int i = 0; i < 24; i++) begin
      @(negedge mclk_i);
      if (chain_clk_o === 1'b1 && prev_clk === 1'b0) begin
        if (last >= 0) check(32'(i - last), 32'(DIV));
        check(32'(prev_tick), 32'h1);
        last = i;
      end
      prev_clk = chain_clk_o;
      prev_tick = sm_tick_o;
    end
    sm_clk_en_i = 1'b0;
    repeat (8) @(negedge mclk_i);
    check(32'(chain_clk_o), 32'h0);
    // scan output shares data line 14
    scan_mode_i = 1'b1;
    for (int v = 0; v < 2; v++) begin
      scan_out_i = v[0];
      repeat (4) @(negedge mclk_i);
      check(32'(bus.data[SMPI_SCAN_OUT_BIT]), 32'(v[0]));
    end
    scan_mode_i = 1'b0;
    repeat (4) @(negedge mclk_i);
    // corner words, then a random back-to-back burst
    xfer(1'b0, 5'h1f, 32'hffff_ffff);
    xfer(1'b1, 5'h00, 32'h0);
    for (int i = 0; i < 12; i++) begin
      r = $random(seed);
      xfer(r[31], r[4:0], $random(seed));
    end
    // asynchronous reset acts between clock edges
    repeat (4) @(negedge mclk_i);
    #5 rst_n_i = 1'b0;
    #2 check(32'({chain_mode_sel_o, bus.xfer_ack_n_oe}), 32'h2);
    @(negedge mclk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge mclk_i);
    xfer(1'b1, 5'h0a, 32'h0);
    complete_run();
  end
  // watchdog well beyond the expected run length
  initial begin
    #400000;
    failures++;
    complete_run();
  end
endmodule
`default_nettype wire
